/* dv/eatc_tb.sv */
`timescale 1ns/1ns
module testbench;
   logic        ref_clk;
   logic        rst_b;
   logic [4:0]  reg_addr;
   logic [15:0] reg_wdata;
   logic        reg_wr;
   logic        reg_rd;
   logic [15:0] reg_rdata;
   logic [1:0]  link_speed;
   logic        mac_tx_lpi;
   logic        mac_tx_idle;
   logic        media_rx_lpi;
   logic [3:0]  led_state;
   logic        media_tx_lpi;
   logic        mac_rx_lpi;
   logic [3:0]  indicator_outputs;
   logic        low_power_10m_mode;
   logic        force_1000_free_role;
   logic [3:0]  trim_10m;
   logic [3:0]  trim_10m_lp;
   int          num_errors;
   int          n_compared;

   eatc_bank DUT (
      .ref_clk              (ref_clk),
      .rst_b                (rst_b),
      .reg_addr             (reg_addr),
      .reg_wdata            (reg_wdata),
      .reg_wr               (reg_wr),
      .reg_rd               (reg_rd),
      .reg_rdata            (reg_rdata),
      .link_speed           (link_speed),
      .mac_tx_lpi           (mac_tx_lpi),
      .mac_tx_idle          (mac_tx_idle),
      .media_rx_lpi         (media_rx_lpi),
      .led_state            (led_state),
      .media_tx_lpi         (media_tx_lpi),
      .mac_rx_lpi           (mac_rx_lpi),
      .indicator_outputs    (indicator_outputs),
      .low_power_10m_mode   (low_power_10m_mode),
      .force_1000_free_role (force_1000_free_role),
      .trim_10m             (trim_10m),
      .trim_10m_lp          (trim_10m_lp)
   );

   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string msg);
      n_compared++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] %0t %s: seen %h expected %h", $time, msg, seen, exp);
      end
   endtask

   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      @(posedge ref_clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr    <= 1'b0;
   endtask

   // Read data only stand in the cycle after the strobe
   task automatic rdc(input logic [4:0] a, input logic [15:0] exp, input string msg);
      @(posedge ref_clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd   <= 1'b0;
      #1 chk(reg_rdata, exp, msg);
   endtask

   task automatic settle;
      repeat (2) @(posedge ref_clk);
      #1;
   endtask

   task automatic t_reset;
      chk(trim_10m, 16'h000b, "trim 10m reset");
      chk(trim_10m_lp, 16'h000e, "trim lp reset");
      chk(indicator_outputs, 16'h000f, "leds off at reset");
      chk(low_power_10m_mode, 16'h0000, "low power reset");
      rdc(eatc_pkg::REG_TX_TRIM, 16'h0000, "paged reg on main page");
      wr(eatc_pkg::REG_PAGE, eatc_pkg::PAGE_EXT2);
      rdc(eatc_pkg::REG_TX_TRIM, 16'h00be, "trim reset read");
      rdc(eatc_pkg::REG_EEE_CTL, 16'h0000, "eee reset read");
      $display("t_reset done");
   endtask

   task automatic t_fields;
      wr(eatc_pkg::REG_EEE_CTL, 16'hffff);
      rdc(eatc_pkg::REG_EEE_CTL, 16'hbc3f, "reserved eee bits");
      chk(low_power_10m_mode, 16'h0001, "low power set");
      wr(eatc_pkg::REG_TX_TRIM, 16'hff5a);
      rdc(eatc_pkg::REG_TX_TRIM, 16'h005a, "trim readback");
      chk(trim_10m, 16'h0005, "trim 10m out");
      chk(trim_10m_lp, 16'h000a, "trim lp out");
      rdc(5'h12, 16'h0000, "unmapped page 2 reg");
      $display("t_fields done");
   endtask

   task automatic t_led;
      wr(eatc_pkg::REG_EEE_CTL, 16'h1400);
      led_state <= 4'h3;
      settle;
      chk(indicator_outputs, 16'h0009, "led inversion");
      $display("t_led done");
   endtask

   task automatic t_force1g;
      wr(eatc_pkg::REG_BASIC_CTL, 16'h0040);
      wr(eatc_pkg::REG_EEE_CTL, 16'h0020);
      settle;
      chk(force_1000_free_role, 16'h0001, "1g free role on");
      rdc(eatc_pkg::REG_BASIC_CTL, 16'h0040, "reg0 beside paging");
      wr(eatc_pkg::REG_BASIC_CTL, 16'h2040);
      settle;
      chk(force_1000_free_role, 16'h0000, "speed not 2'b10");
      $display("t_force1g done");
   endtask

   // Every inhibit pattern at every speed
   task automatic t_inhibit;
      logic [3:0] v;
      logic       tx_off;
      logic       rx_off;
      @(posedge ref_clk);
      mac_tx_lpi   <= 1'b1;
      media_rx_lpi <= 1'b1;
      for (int s = 0; s < 3; s++) begin
         for (int i = 0; i < 16; i++) begin
            v = i[3:0];
            tx_off = (s == 1 && v[3]) || (s == 2 && v[1]);
            rx_off = (s == 1 && v[2]) || (s == 2 && v[0]);
            wr(eatc_pkg::REG_EEE_CTL, {12'h000, v});
            link_speed <= s[1:0];
            settle;
            chk(media_tx_lpi, {15'h0, !tx_off}, "tx lpi inhibit");
            chk(mac_rx_lpi, {15'h0, !rx_off}, "rx lpi inhibit");
         end
      end
      $display("t_inhibit done");
   endtask

   task automatic t_force_lpi;
      @(posedge ref_clk);
      mac_tx_lpi   <= 1'b0;
      media_rx_lpi <= 1'b0;
      mac_tx_idle  <= 1'b1;
      wr(eatc_pkg::REG_EEE_CTL, 16'h0010);
      settle;
      chk(media_tx_lpi, 16'h0001, "forced lpi on idles");
      chk(mac_rx_lpi, 16'h0000, "no rx lpi");
      @(posedge ref_clk);
      mac_tx_idle <= 1'b0;
      settle;
      chk(media_tx_lpi, 16'h0000, "no forced lpi without idles");
      @(posedge ref_clk);
      mac_tx_idle <= 1'b1;
      wr(eatc_pkg::REG_EEE_CTL, 16'h0000);
      settle;
      chk(media_tx_lpi, 16'h0000, "idles pass through");
      $display("t_force_lpi done");
   endtask

   // Leaving page 2 must hide the bank, and a reset mid-run restores defaults
   task automatic t_page;
      wr(eatc_pkg::REG_EEE_CTL, 16'h8000);
      wr(eatc_pkg::REG_PAGE, eatc_pkg::PAGE_MAIN);
      wr(eatc_pkg::REG_EEE_CTL, 16'h0000);
      rdc(eatc_pkg::REG_EEE_CTL, 16'h0000, "bank hidden on main");
      wr(eatc_pkg::REG_PAGE, 16'h0003);
      rdc(eatc_pkg::REG_EEE_CTL, 16'h0000, "bank hidden on page 3");
      wr(eatc_pkg::REG_PAGE, eatc_pkg::PAGE_EXT2);
      rdc(eatc_pkg::REG_EEE_CTL, 16'h8000, "write on main ignored");
      @(posedge ref_clk);
      rst_b <= 1'b0;
      settle;
      chk(low_power_10m_mode, 16'h0000, "low power after reset");
      chk(trim_10m, 16'h000b, "trim after reset");
      @(posedge ref_clk);
      rst_b <= 1'b1;
      rdc(eatc_pkg::REG_TX_TRIM, 16'h0000, "page back to main");
      $display("t_page done");
   endtask

   task automatic wrap_up;
      $display("compares %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // Waits are all fixed, so this only guards a stuck run
   initial begin
      #400000;
      num_errors++;
      $display("[ERR] %0t run limit reached", $time);
      wrap_up;
   end

   initial begin
      num_errors   = 0;
      n_compared   = 0;
      rst_b        = 1'b0;
      reg_addr     = 5'h00;
      reg_wdata    = 16'h0000;
      reg_wr       = 1'b0;
      reg_rd       = 1'b0;
      link_speed   = 2'h0;
      mac_tx_lpi   = 1'b0;
      mac_tx_idle  = 1'b0;
      media_rx_lpi = 1'b0;
      led_state    = 4'h0;
      repeat (8) @(posedge ref_clk);
      rst_b <= 1'b1;
      settle;
      t_reset;
      t_fields;
      t_led;
      t_force1g;
      t_inhibit;
      t_force_lpi;
      t_page;
      wrap_up;
   end
endmodule

/* pkg/eatc_ctl_if.sv */
`timescale 1ns/1ns
interface eatc_ctl_if;
   logic                        force_lpi;
   logic                        inh_tx100;
   logic                        inh_rx100;
   logic                        inh_tx1g;
   logic                        inh_rx1g;
   logic [eatc_pkg::LED_N-1:0]  led_inv;

   modport bank (output force_lpi, inh_tx100, inh_rx100, inh_tx1g, inh_rx1g, led_inv);
   modport user (input  force_lpi, inh_tx100, inh_rx100, inh_tx1g, inh_rx1g, led_inv);
endinterface

/* pkg/eatc_pkg.sv */
package eatc_pkg;
   localparam int          ADDR_W        = 5;
   localparam int          DATA_W        = 16;
   localparam int          LED_N         = 4;

   // Management register numbers
   localparam logic [4:0]  REG_BASIC_CTL = 5'h00;
   localparam logic [4:0]  REG_TX_TRIM   = 5'h10;
   localparam logic [4:0]  REG_EEE_CTL   = 5'h11;
   localparam logic [4:0]  REG_PAGE      = 5'h1f;
   localparam logic [4:0]  PAGED_LO      = 5'h10;
   localparam logic [4:0]  PAGED_HI      = 5'h1e;

   // Page select values
   localparam logic [15:0] PAGE_MAIN     = 16'h0000;
   localparam logic [15:0] PAGE_EXT2     = 16'h0002;
   localparam logic [15:0] PAGE_RST      = 16'h0000;

   // Speed select bits of register 0, kept as {bit 6, bit 13}
   localparam int          SPD_HI_BIT    = 6;
   localparam int          SPD_LO_BIT    = 13;
   localparam logic [1:0]  SPD_SEL_1000  = 2'h2;
   localparam logic [1:0]  SPD_SEL_RST   = 2'h0;

   // Transmit amplitude trim fields
   localparam int          TRIM10_LSB    = 4;
   localparam int          TRIMLP_LSB    = 0;
   localparam int          TRIM_W        = 4;
   localparam logic [3:0]  TRIM10_RST    = 4'hb;
   localparam logic [3:0]  TRIMLP_RST    = 4'he;

   // EEE control fields
   localparam int          EEE_TE_BIT    = 15;
   localparam int          LED_INV_LSB   = 10;
   localparam int          FORCE1G_BIT   = 5;
   localparam int          FORCE_LPI_BIT = 4;
   localparam int          INH_TX100_BIT = 3;
   localparam int          INH_RX100_BIT = 2;
   localparam int          INH_TX1G_BIT  = 1;
   localparam int          INH_RX1G_BIT  = 0;
   localparam logic [15:0] EEE_WMASK     = 16'hbc3f;
   localparam logic [15:0] EEE_RST       = 16'h0000;

   // Live link speed codes
   localparam logic [1:0]  SPEED_10      = 2'h0;
   localparam logic [1:0]  SPEED_100     = 2'h1;
   localparam logic [1:0]  SPEED_1000    = 2'h2;
endpackage

/* rtl/eatc_bank.sv */
// Behaviour
// - EEE control bit 15, reset 0, puts the port into the low-amplitude 10 Mb/s mode.
// - EEE control bits 13:10, reset 0, invert the matching LED outputs; clear means low.
// - Bit 5, reset 0, allows 1000BASE-T link-up without forced role when reg 0 speed is 2'b10.
// - Bit 4, reset 0, makes the test frame generator send LPI in place of MAC idles.
// - With bit 4 clear, MAC idles reach the media transmit path unchanged.
// - Bit 3, reset 0, blocks transmit LPI from the MAC, but not from the test frame generator, toward the media at 100 Mb/s.
// - Bit 2, reset 0, blocks receive LPI toward the MAC at 100 Mb/s.
// - Bit 1, reset 0, blocks transmit LPI from the MAC, but not from the test frame generator, toward the media at 1000 Mb/s.
// - Bit 0, reset 0, blocks receive LPI toward the MAC at 1000 Mb/s.
// - With page 2 selected registers 16 to 30 map to page 2; registers 0 to 15 ignore paging.
`timescale 1ns/1ns
module eatc_bank (
   input  wire logic                          ref_clk,
   input  wire logic                          rst_b,
   input  wire logic [eatc_pkg::ADDR_W-1:0]   reg_addr,
   input  wire logic [eatc_pkg::DATA_W-1:0]   reg_wdata,
   input  wire logic                          reg_wr,
   input  wire logic                          reg_rd,
   output logic      [eatc_pkg::DATA_W-1:0]   reg_rdata,
   input  wire logic [1:0]                    link_speed,
   input  wire logic                          mac_tx_lpi,
   input  wire logic                          mac_tx_idle,
   input  wire logic                          media_rx_lpi,
   input  wire logic [eatc_pkg::LED_N-1:0]    led_state,
   output logic                               media_tx_lpi,
   output logic                               mac_rx_lpi,
   output logic      [eatc_pkg::LED_N-1:0]    indicator_outputs,
   output logic                               low_power_10m_mode,
   output logic                               force_1000_free_role,
   output logic      [eatc_pkg::TRIM_W-1:0]   trim_10m,
   output logic      [eatc_pkg::TRIM_W-1:0]   trim_10m_lp
);
   localparam int TW = eatc_pkg::TRIM_W;

   logic [15:0] page_r;
   logic [1:0]  spd_sel_r;
   logic [7:0]  trim_r;
   logic [15:0] eee_r;
   logic [15:0] rdata_r;
   logic        force1g_r;

   eatc_ctl_if ctl ();

   // Address decode
   wire ext2_sel  = page_r == eatc_pkg::PAGE_EXT2;
   wire in_paged  = (reg_addr >= eatc_pkg::PAGED_LO) && (reg_addr <= eatc_pkg::PAGED_HI);
   wire hit_basic = reg_addr == eatc_pkg::REG_BASIC_CTL;
   wire hit_page  = reg_addr == eatc_pkg::REG_PAGE;
   wire hit_trim  = ext2_sel && in_paged && (reg_addr == eatc_pkg::REG_TX_TRIM);
   wire hit_eee   = ext2_sel && in_paged && (reg_addr == eatc_pkg::REG_EEE_CTL);

   wire wr_basic  = reg_wr & hit_basic;
   wire wr_page   = reg_wr & hit_page;
   wire wr_trim   = reg_wr & hit_trim;
   wire wr_eee    = reg_wr & hit_eee;

   // Register 0 shows only the speed select pair; its other bits read zero
   wire [15:0] basic_view = (16'(spd_sel_r[1]) << eatc_pkg::SPD_HI_BIT)
                          | (16'(spd_sel_r[0]) << eatc_pkg::SPD_LO_BIT);
   wire [1:0]  spd_sel_nxt = {reg_wdata[eatc_pkg::SPD_HI_BIT], reg_wdata[eatc_pkg::SPD_LO_BIT]};

   wire [15:0] eee_nxt = reg_wdata & eatc_pkg::EEE_WMASK;
   wire [15:0] trim_view = {8'h00, trim_r};

   // Unmapped and foreign-page registers read zero
   wire [15:0] rd_mux = hit_basic ? basic_view :
                        hit_page  ? page_r     :
                        hit_trim  ? trim_view  :
                        hit_eee   ? eee_r      : 16'h0000;
   wire [15:0] rdata_nxt = reg_rd ? rd_mux : 16'h0000;

   // Role-free gigabit only when register 0 asks for 1000 Mb/s
   wire force1g_nxt = eee_r[eatc_pkg::FORCE1G_BIT] & (spd_sel_r == eatc_pkg::SPD_SEL_1000);

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         page_r <= eatc_pkg::PAGE_RST;
      end else if (wr_page) begin
         page_r <= reg_wdata;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         spd_sel_r <= eatc_pkg::SPD_SEL_RST;
      end else if (wr_basic) begin
         spd_sel_r <= spd_sel_nxt;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         trim_r <= {eatc_pkg::TRIM10_RST, eatc_pkg::TRIMLP_RST};
      end else if (wr_trim) begin
         trim_r <= reg_wdata[7:0];
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         eee_r <= eatc_pkg::EEE_RST;
      end else if (wr_eee) begin
         eee_r <= eee_nxt;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         rdata_r   <= 16'h0000;
         force1g_r <= 1'b0;
      end else begin
         rdata_r   <= rdata_nxt;
         force1g_r <= force1g_nxt;
      end
   end

   assign ctl.force_lpi = eee_r[eatc_pkg::FORCE_LPI_BIT];
   assign ctl.inh_tx100 = eee_r[eatc_pkg::INH_TX100_BIT];
   assign ctl.inh_rx100 = eee_r[eatc_pkg::INH_RX100_BIT];
   assign ctl.inh_tx1g  = eee_r[eatc_pkg::INH_TX1G_BIT];
   assign ctl.inh_rx1g  = eee_r[eatc_pkg::INH_RX1G_BIT];
   assign ctl.led_inv   = eee_r[eatc_pkg::LED_INV_LSB +: eatc_pkg::LED_N];

   eatc_lpi_gate u_lpi (
      .ref_clk        (ref_clk),
      .rst_b          (rst_b),
      .ctl            (ctl.user),
      .link_speed     (link_speed),
      .mac_tx_lpi     (mac_tx_lpi),
      .mac_tx_idle    (mac_tx_idle),
      .media_rx_lpi   (media_rx_lpi),
      .media_tx_lpi_r (media_tx_lpi),
      .mac_rx_lpi_r   (mac_rx_lpi)
   );

   eatc_led_pol #(
      .LED_N (eatc_pkg::LED_N)
   ) u_led (
      .ref_clk             (ref_clk),
      .rst_b               (rst_b),
      .ctl                 (ctl.user),
      .led_state           (led_state),
      .indicator_outputs_r (indicator_outputs)
   );

   assign reg_rdata            = rdata_r;
   assign low_power_10m_mode   = eee_r[eatc_pkg::EEE_TE_BIT];
   assign force_1000_free_role = force1g_r;
   assign trim_10m             = trim_r[eatc_pkg::TRIM10_LSB +: TW];
   assign trim_10m_lp          = trim_r[eatc_pkg::TRIMLP_LSB +: TW];

   // Checks
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_b);

   wire is_100  = link_speed == eatc_pkg::SPEED_100;
   wire is_1000 = link_speed == eatc_pkg::SPEED_1000;

   AST_TE_MODE: assert property (
      wr_eee |=> low_power_10m_mode == $past(reg_wdata[eatc_pkg::EEE_TE_BIT]))
      else $error("low power 10M mode does not follow the EEE write");

   // Reset drives the pins to off, so the release edge itself is not judged
   AST_LED_POL: assert property (
      rst_b |=> indicator_outputs == ($past(~led_state) ^ $past(ctl.led_inv)))
      else $error("indicator polarity wrong");

   AST_FORCE1G: assert property (
      wr_eee && reg_wdata[eatc_pkg::FORCE1G_BIT] && spd_sel_r == eatc_pkg::SPD_SEL_1000
      && !wr_basic |=> ##1 force_1000_free_role)
      else $error("gigabit role-free link-up not granted");

   AST_FORCE1G_OFF: assert property (
      spd_sel_r != eatc_pkg::SPD_SEL_1000 |=> !force_1000_free_role)
      else $error("role-free link-up without gigabit speed select");

   AST_FORCE_LPI: assert property (
      ctl.force_lpi && mac_tx_idle && !mac_tx_lpi |=> media_tx_lpi)
      else $error("forced LPI not sent on idle");

   AST_PASS_IDLE: assert property (
      !ctl.force_lpi && !mac_tx_lpi |=> !media_tx_lpi)
      else $error("idle altered while forcing is off");

   AST_INH_TX100: assert property (
      is_100 && ctl.inh_tx100 && !ctl.force_lpi |=> !media_tx_lpi)
      else $error("transmit LPI leaked at 100M");

   AST_INH_RX100: assert property (
      is_100 && ctl.inh_rx100 |=> !mac_rx_lpi)
      else $error("receive LPI leaked at 100M");

   AST_INH_TX1G: assert property (
      is_1000 && ctl.inh_tx1g && !ctl.force_lpi |=> !media_tx_lpi)
      else $error("transmit LPI leaked at 1000M");

   AST_INH_RX1G: assert property (
      is_1000 && ctl.inh_rx1g |=> !mac_rx_lpi)
      else $error("receive LPI leaked at 1000M");

   AST_RX_PASS: assert property (
      media_rx_lpi && !is_100 && !is_1000 |=> mac_rx_lpi)
      else $error("receive LPI dropped without inhibit");

   AST_PAGE_GATE: assert property (
      reg_wr && !ext2_sel && reg_addr == eatc_pkg::REG_EEE_CTL |=> $stable(eee_r))
      else $error("EEE control written outside page 2");

   AST_LOW_REGS: assert property (
      reg_rd && hit_basic |=> reg_rdata == $past(basic_view))
      else $error("register 0 read depends on page");

   AST_TRIM_RB: assert property (
      wr_trim ##1 !reg_wr ##1 (reg_rd && hit_trim && !reg_wr)
      |=> reg_rdata == {8'h00, $past(reg_wdata[7:0], 3)})
      else $error("trim readback mismatch");

   AST_RSVD: assert property (
      reg_rd && hit_eee |=> (reg_rdata & ~eatc_pkg::EEE_WMASK) == 16'h0000)
      else $error("reserved EEE bits not zero");

   AST_RD_ONE: assert property (
      !reg_rd |=> reg_rdata == 16'h0000)
      else $error("read data outside the answer cycle");

   // Pass side of every inhibit, so the blocking checks cannot hold by construction
   AST_TX_PASS100: assert property (
      is_100 && !ctl.inh_tx100 && mac_tx_lpi |=> media_tx_lpi)
      else $error("transmit LPI lost at 100M without inhibit");

   AST_RX_PASS100: assert property (
      is_100 && !ctl.inh_rx100 && media_rx_lpi |=> mac_rx_lpi)
      else $error("receive LPI lost at 100M without inhibit");

   AST_TX_PASS1G: assert property (
      is_1000 && !ctl.inh_tx1g && mac_tx_lpi |=> media_tx_lpi)
      else $error("transmit LPI lost at 1000M without inhibit");

   AST_RX_PASS1G: assert property (
      is_1000 && !ctl.inh_rx1g && media_rx_lpi |=> mac_rx_lpi)
      else $error("receive LPI lost at 1000M without inhibit");

   AST_TX_PASS10: assert property (
      mac_tx_lpi && !is_100 && !is_1000 |=> media_tx_lpi)
      else $error("transmit LPI dropped without inhibit");

   AST_FORCE_IDLE: assert property (
      ctl.force_lpi && !mac_tx_idle && !mac_tx_lpi |=> !media_tx_lpi)
      else $error("forced LPI sent without MAC idles");

   AST_FORCE1G_BIT: assert property (
      !eee_r[eatc_pkg::FORCE1G_BIT] |=> !force_1000_free_role)
      else $error("role-free link-up without its enable");

   AST_SPD_WR: assert property (
      wr_basic |=> spd_sel_r == $past(spd_sel_nxt))
      else $error("speed select not taken from register 0 write");

   AST_EEE_WR: assert property (
      wr_eee |=> eee_r == ($past(reg_wdata) & eatc_pkg::EEE_WMASK))
      else $error("EEE control write not masked");

   AST_PAGE_WR: assert property (
      wr_page |=> page_r == $past(reg_wdata))
      else $error("page select not stored");

   AST_TRIM_OUT: assert property (
      wr_trim |=> trim_10m == $past(reg_wdata[eatc_pkg::TRIM10_LSB +: TW])
      && trim_10m_lp == $past(reg_wdata[eatc_pkg::TRIMLP_LSB +: TW]))
      else $error("trim outputs do not follow the write");

   AST_RD_TRIM: assert property (
      reg_rd && hit_trim |=> reg_rdata == {8'h00, $past(trim_r)})
      else $error("trim read does not show the register");

   AST_RD_EEE: assert property (
      reg_rd && hit_eee |=> reg_rdata == $past(eee_r))
      else $error("EEE control read does not show the register");

   AST_RD_HIDDEN: assert property (
      reg_rd && in_paged && !ext2_sel |=> reg_rdata == 16'h0000)
      else $error("paged register visible outside page 2");

   // Registers move only on their own write
   AST_TRIM_HOLD: assert property (
      !wr_trim |=> $stable(trim_r))
      else $error("trim changed without a write");

   AST_EEE_HOLD: assert property (
      !wr_eee |=> $stable(eee_r))
      else $error("EEE control changed without a write");

   AST_PAGE_HOLD: assert property (
      !wr_page |=> $stable(page_r))
      else $error("page select changed without a write");

   AST_SPD_HOLD: assert property (
      !wr_basic |=> $stable(spd_sel_r))
      else $error("speed select changed without a write");

   COV_PAGE2: cover property (wr_page && reg_wdata == eatc_pkg::PAGE_EXT2 ##[1:20] wr_eee);
   COV_INH100: cover property (is_100 && ctl.inh_rx100 && media_rx_lpi);
   COV_FORCE: cover property (ctl.force_lpi && mac_tx_idle ##1 media_tx_lpi);
   COV_INH1G: cover property (is_1000 && ctl.inh_tx1g && mac_tx_lpi);
   COV_BACK: cover property (wr_page && reg_wdata == eatc_pkg::PAGE_MAIN ##1 reg_rd && hit_basic);
endmodule

/* rtl/eatc_led_pol.sv */
`timescale 1ns/1ns
module eatc_led_pol #(
   parameter int LED_N = eatc_pkg::LED_N
) (
   input  wire logic             ref_clk,
   input  wire logic             rst_b,
   eatc_ctl_if.user              ctl,
   input  wire logic [LED_N-1:0] led_state,
   output logic      [LED_N-1:0] indicator_outputs_r
);
   // Idle LED drives high, so lit is low unless inverted
   for (genvar i = 0; i < LED_N; i++) begin : g_led
      wire pin_nxt = ~led_state[i] ^ ctl.led_inv[i];
      always_ff @(posedge ref_clk or negedge rst_b) begin
         if (!rst_b) begin
            indicator_outputs_r[i] <= 1'b1;
         end else begin
            indicator_outputs_r[i] <= pin_nxt;
         end
      end
   end
endmodule

/* rtl/eatc_lpi_gate.sv */
`timescale 1ns/1ns
module eatc_lpi_gate (
   input  wire logic        ref_clk,
   input  wire logic        rst_b,
   eatc_ctl_if.user         ctl,
   input  wire logic [1:0]  link_speed,
   input  wire logic        mac_tx_lpi,
   input  wire logic        mac_tx_idle,
   input  wire logic        media_rx_lpi,
   output logic             media_tx_lpi_r,
   output logic             mac_rx_lpi_r
);
   wire is_100  = link_speed == eatc_pkg::SPEED_100;
   wire is_1000 = link_speed == eatc_pkg::SPEED_1000;

   wire tx_inh  = (is_100 & ctl.inh_tx100) | (is_1000 & ctl.inh_tx1g);
   wire rx_inh  = (is_100 & ctl.inh_rx100) | (is_1000 & ctl.inh_rx1g);

   // Test frame generator swaps plain idles for LPI
   wire tfg_lpi = ctl.force_lpi & mac_tx_idle & ~mac_tx_lpi;

   wire media_tx_lpi_nxt = (mac_tx_lpi & ~tx_inh) | tfg_lpi;
   wire mac_rx_lpi_nxt   = media_rx_lpi & ~rx_inh;

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         media_tx_lpi_r <= 1'b0;
         mac_rx_lpi_r   <= 1'b0;
      end else begin
         media_tx_lpi_r <= media_tx_lpi_nxt;
         mac_rx_lpi_r   <= mac_rx_lpi_nxt;
      end
   end
endmodule
